// file: shared/srt_pkg.sv
// Shared constants and types for the SDRAM pattern tester
package srt_pkg;

  // Memory geometry: 64MB bank, 16-bit words
  localparam int MEM_BYTES = 64 * 1024 * 1024;
  localparam int MEM_DATA_W = 16;
  localparam int MEM_WORDS_DEF = MEM_BYTES / (MEM_DATA_W / 8);
  localparam int MEM_ADDR_W = 25;

  // Board reference clock and lamp blink half period
  localparam int REF_CLK_KHZ = 50_000;
  localparam int LAMP_HALF_MS = 250;
  // Reference clock edges per blink half period
  localparam int LAMP_HALF_EDGES = REF_CLK_KHZ * LAMP_HALF_MS;
  localparam int BLINK_CNT_W = 24;

  // Lamp bit positions and values
  localparam int LAMP_RESET = 0;
  localparam int LAMP_PASS = 1;
  localparam int LAMP_CLK = 2;
  localparam logic [2:0] LAMPS_ALL_ON = 3'h7;
  localparam logic [2:0] LAMPS_RESET_VAL = 3'h0;

  // Pattern generator seed and feedback taps
  localparam logic [31:0] LFSR_SEED = 32'h1ace_5eed;
  localparam logic [31:0] LFSR_TAPS = 32'h8020_0003;

  // Test sequencer states
  typedef enum logic [2:0] {
    ST_HELD,
    ST_WRITE,
    ST_READ,
    ST_RD_WAIT,
    ST_DONE
  } srt_state_e;

  // Requests toward the memory controller slave port
  typedef struct packed {
    logic [MEM_ADDR_W-1:0] address;
    logic write;
    logic read;
    logic [MEM_DATA_W-1:0] writedata;
  } srt_mem_req_s;

  // Answers from the memory controller slave port
  typedef struct packed {
    logic waitrequest;
    logic readdatavalid;
    logic [MEM_DATA_W-1:0] readdata;
  } srt_mem_rsp_s;

endpackage : srt_pkg

// file: rtl/srt_pattern_gen.sv
`timescale 1ns/1ns
// Pseudo-random word source; same sequence after every restart
module srt_pattern_gen
  import srt_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_restart,
  input wire logic i_advance,
  output logic [MEM_DATA_W-1:0] o_value
);

  // Galois shift register state
  logic [31:0] lfsr_reg;
  logic [31:0] lfsr_next;
  // One step of the sequence
  wire [31:0] lfsr_step = lfsr_reg[0] ? ((lfsr_reg >> 1) ^ LFSR_TAPS) : (lfsr_reg >> 1);

  // Restart wins over advance
  assign lfsr_next = i_restart ? LFSR_SEED : (i_advance ? lfsr_step : lfsr_reg);

  // State register
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      lfsr_reg <= LFSR_SEED;
    else
      lfsr_reg <= lfsr_next;
  end

  // Current pattern word
  assign o_value = lfsr_reg[MEM_DATA_W-1:0];

endmodule : srt_pattern_gen

// file: rtl/srt_tester.sv
`timescale 1ns/1ns
module srt_tester
  import srt_pkg::*;
#(
  parameter int MEM_WORDS = MEM_WORDS_DEF,
  parameter int BLINK_EDGES = LAMP_HALF_EDGES
)
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_start_btn_n,
  input wire logic i_ref_clk,
  input wire srt_mem_rsp_s i_mem,
  output srt_mem_req_s o_mem,
  output logic [2:0] o_status_lamps
);

  // Last word address of the bank
  localparam logic [MEM_ADDR_W-1:0] LAST_ADDR = MEM_ADDR_W'(MEM_WORDS - 1);
  // Blink counter wrap value
  localparam logic [BLINK_CNT_W-1:0] BLINK_LAST = BLINK_CNT_W'(BLINK_EDGES - 1);

  // Button synchroniser stages
  logic btn_s1_reg;
  logic btn_s2_reg;
  // Reference clock sampling stages
  logic ref_s1_reg;
  logic ref_s2_reg;
  logic ref_s3_reg;
  // Blink divider
  logic [BLINK_CNT_W-1:0] blink_cnt_reg;
  logic [BLINK_CNT_W-1:0] blink_cnt_next;
  logic blink_reg;
  logic blink_next;
  // Sequencer
  srt_state_e state_reg;
  srt_state_e state_next;
  logic [MEM_ADDR_W-1:0] addr_reg;
  logic [MEM_ADDR_W-1:0] addr_next;
  srt_mem_req_s req_reg;
  srt_mem_req_s req_next;
  // Result and lamps
  logic fail_reg;
  logic fail_next;
  logic [2:0] lamps_reg;
  logic [2:0] lamps_next;
  // Expected word from the generator
  logic [MEM_DATA_W-1:0] exp_value;

  // Decoded conditions
  wire btn_held = ~btn_s2_reg;
  wire ref_rise = ref_s2_reg & ~ref_s3_reg;
  wire blink_wrap = ref_rise & (blink_cnt_reg == BLINK_LAST);
  wire addr_last = (addr_reg == LAST_ADDR);
  wire wr_taken = req_reg.write & ~i_mem.waitrequest;
  wire rd_taken = req_reg.read & ~i_mem.waitrequest;
  wire rd_back = (state_reg == ST_RD_WAIT) & i_mem.readdatavalid;
  wire mismatch = rd_back & ~btn_held & (i_mem.readdata != exp_value);
  wire passed = (state_reg == ST_DONE) & ~fail_reg;
  // Generator steps once per written or returned word
  wire gen_advance = wr_taken | rd_back;
  // Generator rewinds on press and after the final write
  wire gen_restart = btn_held | ((state_reg == ST_WRITE) & wr_taken & addr_last);

  // Pattern source shared by both phases
  srt_pattern_gen u_gen (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_restart(gen_restart),
    .i_advance(gen_advance),
    .o_value(exp_value)
  );

  // Two-flop synchronisers for the button and reference clock
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      btn_s1_reg <= 1'b1;
      btn_s2_reg <= 1'b1;
      ref_s1_reg <= 1'b0;
      ref_s2_reg <= 1'b0;
      ref_s3_reg <= 1'b0;
    end
    else
    begin
      btn_s1_reg <= i_start_btn_n;
      btn_s2_reg <= btn_s1_reg;
      ref_s1_reg <= i_ref_clk;
      ref_s2_reg <= ref_s1_reg;
      ref_s3_reg <= ref_s2_reg;
    end
  end

  // Divider counts reference edges, so a dead source stops it
  assign blink_cnt_next = ref_rise ? (blink_wrap ? '0 : blink_cnt_reg + 1'b1)
                                   : blink_cnt_reg;
  assign blink_next = blink_wrap ? ~blink_reg : blink_reg;

  // Blink divider registers
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      blink_cnt_reg <= '0;
      blink_reg <= 1'b0;
    end
    else
    begin
      blink_cnt_reg <= blink_cnt_next;
      blink_reg <= blink_next;
    end
  end

  // Sequencer next state; all bus timing on the controller clock
  always_comb
  begin
    state_next = state_reg;
    addr_next = addr_reg;
    req_next = req_reg;
    if (btn_held)
    begin
      // Held: park and rewind everything
      state_next = ST_HELD;
      addr_next = '0;
      req_next = '0;
    end
    else
    begin
      case (state_reg)
        // Release of the button launches the run
        ST_HELD:
        begin
          state_next = ST_WRITE;
        end
        // Write phase over every word
        ST_WRITE:
        begin
          if (wr_taken)
          begin
            req_next.write = 1'b0;
            if (addr_last)
            begin
              // Reads begin only once every word is written
              addr_next = '0;
              state_next = ST_READ;
            end
            else
              addr_next = addr_reg + 1'b1;
          end
          else if (!req_reg.write)
          begin
            // Issue the next pattern word
            req_next.write = 1'b1;
            req_next.address = addr_reg;
            req_next.writedata = exp_value;
          end
        end
        // Read request, one outstanding at a time
        ST_READ:
        begin
          if (rd_taken)
          begin
            req_next.read = 1'b0;
            state_next = ST_RD_WAIT;
          end
          else if (!req_reg.read)
          begin
            req_next.read = 1'b1;
            req_next.address = addr_reg;
          end
        end
        // Wait for the returned word
        ST_RD_WAIT:
        begin
          if (i_mem.readdatavalid)
          begin
            if (addr_last)
              state_next = ST_DONE;
            else
            begin
              addr_next = addr_reg + 1'b1;
              state_next = ST_READ;
            end
          end
        end
        // Finished; wait for the next press
        ST_DONE:
        begin
          state_next = ST_DONE;
        end
        default:
        begin
          state_next = ST_HELD;
        end
      endcase
    end
  end

  // Sticky failure; only a press or reset clears it
  assign fail_next = btn_held ? 1'b0 : (fail_reg | mismatch);

  // Lamp pattern
  always_comb
  begin
    lamps_next = LAMPS_RESET_VAL;
    if (btn_held)
      lamps_next = LAMPS_ALL_ON;
    else
    begin
      lamps_next[LAMP_RESET] = 1'b0;
      lamps_next[LAMP_CLK] = blink_reg;
      // Steady only on a clean finish, else blinking
      lamps_next[LAMP_PASS] = passed ? 1'b1 : blink_reg;
    end
  end

  // Sequencer, result and lamp registers
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      state_reg <= ST_HELD;
      addr_reg <= '0;
      req_reg <= '0;
      fail_reg <= 1'b0;
      lamps_reg <= LAMPS_RESET_VAL;
    end
    else
    begin
      state_reg <= state_next;
      addr_reg <= addr_next;
      req_reg <= req_next;
      fail_reg <= fail_next;
      lamps_reg <= lamps_next;
    end
  end

  // Outputs straight from flops
  assign o_mem = req_reg;
  assign o_status_lamps = lamps_reg;

  // Checks
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  // Addresses stay inside the bank
  chk_addr_in_bank: assert property (
    (o_mem.write | o_mem.read) |-> (o_mem.address <= LAST_ADDR))
    else $error("Address beyond bank");

  // No read while writing
  chk_no_early_read: assert property (
    (state_reg == ST_WRITE) |-> !o_mem.read)
    else $error("Read during write phase");

  // Write data is the generator word of that moment
  chk_wdata_pattern: assert property (
    $rose(o_mem.write) |-> (o_mem.writedata == $past(exp_value)))
    else $error("Write data not from generator");

  // Release starts the write phase two cycles on
  chk_start_release: assert property (
    $fell(btn_held) |=> ##1 (state_reg == ST_WRITE))
    else $error("Release did not start test");

  // Held button lights all lamps
  chk_lamps_held: assert property (
    btn_held |=> (o_status_lamps == LAMPS_ALL_ON))
    else $error("Lamps not all on while held");

  // Pass lamp steady after clean finish
  chk_pass_steady: assert property (
    passed && !btn_held |=> o_status_lamps[LAMP_PASS])
    else $error("Pass lamp not steady on pass");

  // Failure keeps pass lamp following the blink
  chk_fail_no_pass: assert property (
    fail_reg && !btn_held |=> (o_status_lamps[LAMP_PASS] == $past(blink_reg)))
    else $error("Pass lamp steady after failure");

  // Blink toggles only on a reference edge
  chk_blink_ref: assert property (
    $changed(blink_reg) |-> $past(ref_rise))
    else $error("Blink moved without reference edge");

  // Press rewinds and clears the result
  chk_press_restart: assert property (
    btn_held |=> (addr_reg == '0) && !fail_reg && (state_reg == ST_HELD))
    else $error("Press did not restart test");

  // Reset lamp dark once running
  chk_reset_lamp: assert property (
    !btn_held |=> !o_status_lamps[LAMP_RESET])
    else $error("Reset lamp lit while running");

  // Mismatch sets fail and it sticks
  chk_fail_sticky: assert property (
    (mismatch || fail_reg) && !btn_held |=> fail_reg)
    else $error("Fail flag lost");

  // Scenarios of interest
  cov_write_done: cover property ((state_reg == ST_WRITE) ##1 (state_reg == ST_READ));
  cov_pass: cover property ((state_reg == ST_RD_WAIT) ##1 passed);
  cov_mismatch: cover property (mismatch);
  cov_restart: cover property ((state_reg == ST_DONE) ##1 btn_held);

endmodule : srt_tester

// file: tb/srt_mem_model.sv
`timescale 1ns/1ns
// Memory controller slave port model with random stalls and read latency
module srt_mem_model
  import srt_pkg::*;
#(
  parameter int MEM_WORDS = 16
)
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_corrupt,
  input wire srt_mem_req_s i_req,
  output srt_mem_rsp_s o_rsp
);
  // Storage, random source and one pending read
  logic [MEM_DATA_W-1:0] mem [MEM_WORDS];
  int seed = 23673;
  int wait_cnt;
  logic pend;
  logic [MEM_ADDR_W-1:0] pend_addr;
  // Accept on a clear waitrequest; answer a read 1 to 4 cycles later
  always @(posedge i_clk)
  begin
    o_rsp.readdatavalid <= 1'b0;
    // Idle data bus shows noise, not the last word
    o_rsp.readdata <= 16'(($random(seed)));
    if (!i_rst_n)
    begin
      o_rsp.waitrequest <= 1'b1;
      pend <= 1'b0;
    end
    else
    begin
      if (!o_rsp.waitrequest && i_req.write)
        mem[i_req.address] <= i_req.writedata;
      if (!o_rsp.waitrequest && i_req.read)
      begin
        pend <= 1'b1;
        pend_addr <= i_req.address;
        wait_cnt <= $random(seed) & 3;
      end
      else if (pend && wait_cnt == 0)
      begin
        // Optional single-bit fault at word 5
        o_rsp.readdata <= mem[pend_addr] ^ {15'h0, i_corrupt && pend_addr == 5};
        o_rsp.readdatavalid <= 1'b1;
        pend <= 1'b0;
      end
      else if (pend)
        wait_cnt <= wait_cnt - 1;
      o_rsp.waitrequest <= ($random(seed) & 3) == 0;
    end
  end
endmodule : srt_mem_model

// file: tb/test_sdram_rw_pattern_tester.sv
`timescale 1ns/1ns
// Self-checking bench for the pattern tester
module test_sdram_rw_pattern_tester;
  import srt_pkg::*;
  localparam int WORDS = 16;
  localparam int BLINK = 4;
  // Design and model signals
  logic i_clk, i_rst_n, i_start_btn_n, i_ref_clk, corrupt;
  srt_mem_rsp_s mem_rsp;
  srt_mem_req_s mem_req;
  logic [2:0] lamps, lamps_q;
  // Bookkeeping
  int n_mismatch = 0;
  int tests_run = 0;
  int seed = 23673;
  int wr_n, rd_n, t, c1, c2;
  // Pass and clock lamp toggle counts, owned by the monitor
  int tog1 = 0;
  int tog2 = 0;
  logic [31:0] lfsr;
  logic rd_pend;

  srt_tester #(.MEM_WORDS(WORDS), .BLINK_EDGES(BLINK)) uut (.i_clk(i_clk),
    .i_rst_n(i_rst_n), .i_start_btn_n(i_start_btn_n), .i_ref_clk(i_ref_clk),
    .i_mem(mem_rsp), .o_mem(mem_req), .o_status_lamps(lamps));
  srt_mem_model #(.MEM_WORDS(WORDS)) mem_model (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_corrupt(corrupt), .i_req(mem_req), .o_rsp(mem_rsp));

  // Clocks: 4 ns controller, 16 ns reference with unrelated phase
  initial
  begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  initial
  begin
    i_ref_clk = 1'b0;
    #3;
    forever #8 i_ref_clk = ~i_ref_clk;
  end

  // Compare and report
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Next pattern state, shift right with feedback
  function automatic logic [31:0] next_lfsr(input logic [31:0] s);
    return (s >> 1) ^ (s[0] ? LFSR_TAPS : 32'h0000_0000);
  endfunction : next_lfsr

  // Bus monitor: order, data and single outstanding read
  always @(posedge i_clk)
  begin
    lamps_q <= lamps;
    if (lamps[1] !== lamps_q[1]) tog1 <= tog1 + 1;
    if (lamps[2] !== lamps_q[2]) tog2 <= tog2 + 1;
    if (!i_start_btn_n || !i_rst_n)
    begin
      wr_n <= 0;
      rd_n <= 0;
      lfsr <= LFSR_SEED;
      rd_pend <= 1'b0;
    end
    else
    begin
      if (mem_req.write && !mem_rsp.waitrequest)
      begin
        check("wr_addr", mem_req.address, wr_n);
        check("wr_data", mem_req.writedata, lfsr[15:0]);
        lfsr <= next_lfsr(lfsr);
        wr_n <= wr_n + 1;
      end
      if (mem_req.read && !mem_rsp.waitrequest)
      begin
        check("rd_addr", mem_req.address, rd_n);
        check("rd_after_wr", wr_n, WORDS);
        check("one_read", rd_pend, 1'b0);
        rd_pend <= 1'b1;
        rd_n <= rd_n + 1;
      end
      if (mem_rsp.readdatavalid) rd_pend <= 1'b0;
    end
  end

  // One press-and-release run; abort_at above 0 returns mid-write, leaving the next run's press to abort it
  task run_test(input logic bad, input int abort_at);
    @(negedge i_clk);
    corrupt = bad;
    i_start_btn_n = 1'b0;
    repeat (6 + ($random(seed) & 3)) @(negedge i_clk);
    check("lamps_held", lamps, LAMPS_ALL_ON);
    i_start_btn_n = 1'b1;
    // Skip the held-to-running lamp change so only real blinks count
    repeat (4) @(negedge i_clk);
    c1 = tog1;
    t = 0;
    while (t < 2000 && (abort_at > 0 ? wr_n < abort_at : rd_n < WORDS))
    begin
      @(negedge i_clk);
      t++;
    end
    check("progress", t < 2000, 1'b1);
    if (abort_at == 0)
    begin
      check("all_read", rd_n, WORDS);
      check("blink_run", tog1 != c1, 1'b1);
      repeat (8) @(negedge i_clk);
      check("reset_lamp", lamps[LAMP_RESET], 1'b0);
      c1 = tog1;
      c2 = tog2;
      repeat (40) @(negedge i_clk);
      check("clk_lamp", tog2 != c2, 1'b1);
      check("pass_blink", tog1 != c1, bad);
      if (!bad) check("pass_on", lamps[LAMP_PASS], 1'b1);
    end
  endtask : run_test

  // Verdict and end of run
  task finish_test;
    if (n_mismatch == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test

  // Main sequence: pass, fail, abort, then a clean pass after restart
  initial
  begin
    i_rst_n = 1'b0;
    i_start_btn_n = 1'b1;
    corrupt = 1'b0;
    repeat (8) @(posedge i_clk);
    @(negedge i_clk);
    i_rst_n = 1'b1;
    repeat (4) @(negedge i_clk);
    check("lamps_rst", lamps, LAMPS_RESET_VAL);
    run_test(1'b0, 0);
    run_test(1'b1, 0);
    run_test(1'b0, 5);
    run_test(1'b0, 0);
    finish_test();
  end

  // Watchdog
  initial
  begin
    #80000;
    n_mismatch++;
    finish_test();
  end
endmodule : test_sdram_rw_pattern_tester
